// [rpva_applier.sv]
`include "rpva_cfg.svh"
`default_nettype none
module rpva_applier (
  input  wire  logic                             ref_clk,
  input  wire  logic                             reset,
  input  wire  logic                             vec_valid,   // one-cycle vector strobe
  input  wire  rpva_pkg::rpva_code_type [19:0]   vec_code,    // symbols of this vector
  input  wire  logic [19:0]                      preload_mask,// pins used by preload
  input  wire  logic [19:0]                      inv_mask,    // register-to-pin inverts
  input  wire  logic                             fuse_inv,    // inversion set by fuse
  input  wire  logic [19:0]                      pin_in,      // sampled pin levels
  output var   logic                             busy,
  output var   logic [19:0]                      pin_out,
  output var   logic [19:0]                      pin_oe,
  output var   logic [19:0]                      reg_load,    // preload register image (q)
  output var   logic                             load_stb,    // pulse: apply preload
  output var   logic                             vec_done,    // pulse: vector finished
  output var   logic                             vec_err,     // set a cycle before done, drops with it
  output var   logic                             vec_reject,  // pulse, one cycle before done
  output var   logic                             normal_stb   // ordinary vector handed on
);
  localparam int SETTLE = `RPVA_SETTLE_CYC;
  rpva_pkg::rpva_state_type state_q;
  rpva_pkg::rpva_code_type [19:0] code_q;     // held vector
  logic [19:0]                    expect_q;   // expected pin level
  logic [19:0]                    check_q;    // pins to compare
  logic [7:0]                     cnt_q;      // settle counter
  logic                           level_any;  // any H or L on a preload pin
  logic [19:0]                    lvl_hit;    // per-pin level code present
  logic                           is_pre;     // clock slot carries preload
  logic                           reject_now; // level codes met a fuse-set inversion

  // the preload code is only looked for in the clock slot; anywhere else
  // it falls through to the ignore handling further down
  assign is_pre = (vec_code[`RPVA_CLK_POS] == `RPVA_CODE_PRE);  // R1

  // a rejected vector must leave every register image and pin untouched,
  // so one shared term gates the register-image and pin writers below
  assign reject_now = level_any && fuse_inv;                     // R8

  // per-pin decode of level codes on preload pins only
  genvar g;
  generate
    for (g = 0; g < `RPVA_PINS; g++) begin : g_dec
      assign lvl_hit[g] = preload_mask[g] &&                     // R9
                          ((code_q[g] == `RPVA_CODE_LOW) || (code_q[g] == `RPVA_CODE_HIGH));
    end
  endgenerate
  assign level_any = |lvl_hit;

  // sequencer: preload vectors run load, settle, then check only if a level pin is set; rejected ones go from load to done
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_q <= rpva_pkg::ST_IDLE;
    end else begin
      unique case (state_q)
        rpva_pkg::ST_IDLE: begin
          if (vec_valid && is_pre) begin
            state_q <= rpva_pkg::ST_LOAD;                     // R1
          end
        end
        rpva_pkg::ST_LOAD: begin
          // fuse-chosen inversion makes level codes unsafe to resolve
          if (level_any && fuse_inv) begin
            state_q <= rpva_pkg::ST_DONE;                     // R8
          end else begin
            state_q <= rpva_pkg::ST_SETTLE;
          end
        end
        rpva_pkg::ST_SETTLE: begin
          if (cnt_q == 8'(SETTLE - 1)) begin
            state_q <= (|check_q) ? rpva_pkg::ST_CHECK : rpva_pkg::ST_DONE;  // R4 R11
          end
        end
        rpva_pkg::ST_CHECK: state_q <= rpva_pkg::ST_DONE;
        rpva_pkg::ST_DONE:  state_q <= rpva_pkg::ST_IDLE;      // R14
        default:            state_q <= rpva_pkg::ST_IDLE;
      endcase
    end
  end

  // capture vector
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      code_q <= '0;
    end else if (state_q == rpva_pkg::ST_IDLE && vec_valid) begin
      code_q <= vec_code;
    end
  end

  // settle counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 8'h00;
    end else if (state_q == rpva_pkg::ST_SETTLE) begin
      cnt_q <= cnt_q + 8'h01;
    end else begin
      cnt_q <= 8'h00;
    end
  end

  // register image and expected levels, built in load state
  // skipped on rejection: a refused vector performs no preload at all
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reg_load <= '0;
      expect_q <= '0;
      check_q  <= '0;
    end else if (state_q == rpva_pkg::ST_LOAD && !reject_now) begin  // R8
      for (int i = 0; i < `RPVA_PINS; i++) begin
        check_q[i] <= lvl_hit[i] && !fuse_inv;                 // R4 R11
        if (preload_mask[i] && i != `RPVA_CLK_POS) begin
          unique case (code_q[i])
            `RPVA_CODE_ZERO: reg_load[i] <= 1'b1;              // R3
            `RPVA_CODE_ONE:  reg_load[i] <= 1'b0;              // R3
            // pin = q xor inversion, so q = level xor inversion
            `RPVA_CODE_LOW: begin
              reg_load[i] <= 1'b0 ^ inv_mask[i];               // R5 R7
              expect_q[i] <= 1'b0;                             // R5
            end
            `RPVA_CODE_HIGH: begin
              reg_load[i] <= 1'b1 ^ inv_mask[i];               // R6 R7
              expect_q[i] <= 1'b1;                             // R6
            end
            default: reg_load[i] <= reg_load[i];               // R2 R13
          endcase
        end
      end
    end
  end

  // load strobe, withheld when the vector is rejected
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      load_stb <= 1'b0;
    end else begin
      load_stb <= (state_q == rpva_pkg::ST_LOAD) && !(level_any && fuse_inv);  // R8
    end
  end

  // pin drive: only preload pins with register codes are driven
  // pins are left as driven afterwards, nothing is restored
  // a rejected vector must not release or drive anything either
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pin_out <= '0;
      pin_oe  <= '0;
    end else if (state_q == rpva_pkg::ST_LOAD && !reject_now) begin  // R8
      for (int i = 0; i < `RPVA_PINS; i++) begin
        if (preload_mask[i] && (code_q[i] == `RPVA_CODE_ZERO || code_q[i] == `RPVA_CODE_ONE))
        begin
          pin_out[i] <= (code_q[i] == `RPVA_CODE_ONE);         // R10
          pin_oe[i]  <= 1'b1;
        end else if (lvl_hit[i]) begin
          pin_oe[i]  <= 1'b0;                                  // outputs released to be read
        end
      end                                                      // others hold: R9 R13
    end
  end

  // result pulses
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      vec_done   <= 1'b0;
      vec_err    <= 1'b0;
      vec_reject <= 1'b0;
    end else begin
      vec_done   <= (state_q == rpva_pkg::ST_DONE);
      vec_reject <= (state_q == rpva_pkg::ST_LOAD) && level_any && fuse_inv;  // R8
      if (state_q == rpva_pkg::ST_CHECK) begin
        vec_err <= |((pin_in ^ expect_q) & check_q);           // R5 R6 R11
      end else if (state_q == rpva_pkg::ST_LOAD) begin
        vec_err <= level_any && fuse_inv;                      // R8
      end else if (state_q == rpva_pkg::ST_IDLE) begin
        vec_err <= 1'b0;
      end
    end
  end

  // busy and hand-off of ordinary vectors
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busy       <= 1'b0;
      normal_stb <= 1'b0;
    end else begin
      busy       <= (state_q != rpva_pkg::ST_IDLE) || (vec_valid && is_pre);
      normal_stb <= (state_q == rpva_pkg::ST_IDLE) && vec_valid && !is_pre;  // R14
    end
  end

  a_reject_no_load: assert property (@(posedge ref_clk) disable iff (reset)
    vec_reject |-> !load_stb) else $error("load issued on rejected vector");  // R8
  a_preload_starts: assert property (@(posedge ref_clk) disable iff (reset)
    (state_q == rpva_pkg::ST_IDLE && vec_valid && is_pre) |=> state_q == rpva_pkg::ST_LOAD)
    else $error("preload code did not start sequence");  // R1
  a_done_after_chk: assert property (@(posedge ref_clk) disable iff (reset)
    (state_q == rpva_pkg::ST_CHECK) |=> ##1 vec_done) else $error("no done after check");  // R11
  a_no_pre_normal: assert property (@(posedge ref_clk) disable iff (reset)
    normal_stb |-> !$past(is_pre)) else $error("preload passed as normal");  // R14

  // level-code preload that is allowed: load state with a level code present
  sequence s_level_load;
    (state_q == rpva_pkg::ST_LOAD) && level_any && !fuse_inv;
  endsequence

  // settle takes two cycles, then one check cycle, then done is pulsed;
  // the delay is written out because a changed settle time moves it
  sequence s_check_end;
    ##3 (state_q == rpva_pkg::ST_DONE) ##1 vec_done;
  endsequence

  // rejection ends the vector one cycle later with the error raised
  sequence s_reject_end;
    ##1 (vec_done && vec_err);
  endsequence

  // an allowed level preload always walks through the pin check
  a_level_checked: assert property (@(posedge ref_clk) disable iff (reset)  // R11
    s_level_load |=> s_check_end)
    else $error("level preload skipped its pin check");

  // a refused vector is reported as an error together with done
  a_reject_reports: assert property (@(posedge ref_clk) disable iff (reset)  // R8
    vec_reject |-> s_reject_end)
    else $error("rejected vector not reported as error");

  // the check state is only reached when some pin is to be compared,
  // so register-level codes alone never trigger a pin check
  a_check_needs_pin: assert property (@(posedge ref_clk) disable iff (reset)  // R4
    (state_q == rpva_pkg::ST_CHECK) |-> (|check_q))
    else $error("pin check entered with nothing to compare");

  // pins outside the preload set keep drive and level during a vector;
  // only checked while busy since the mask may change between vectors
  a_unused_pin_hold: assert property (@(posedge ref_clk) disable iff (reset)  // R9
    busy |=> ($stable(pin_oe & ~preload_mask) && $stable(pin_out & ~preload_mask)))
    else $error("pin outside preload set changed");

  // no register image change is allowed on a refused vector
  a_reject_keeps_reg: assert property (@(posedge ref_clk) disable iff (reset)  // R8
    (state_q == rpva_pkg::ST_LOAD && reject_now) |=> $stable(reg_load))
    else $error("register image changed on rejected vector");
endmodule : rpva_applier
`default_nettype wire

// [rpva_cfg.svh]
// Behaviour
// R1 - clock-position preload code starts preload sequence
// R2 - preload code elsewhere acts as ignore
// R3 - zero/one codes load inverted register output
// R4 - register-level codes never check output pins
// R5 - low code loads register, checks pin 0
// R6 - high code loads register, checks pin 1
// R7 - tester derives register value through inversion
// R8 - fuse-dependent inversion rejects level codes
// R9 - pins unused by preload hold state
// R10 - preload pins not restored afterwards
// R11 - after level preload, test output pins
// R12 - users account for inversion composing vectors
// R13 - ignore code holds input, output untested
// R14 - then continue with next vector normally
`ifndef RPVA_CFG_SVH
`define RPVA_CFG_SVH
`define RPVA_PINS        20
`define RPVA_CLK_POS     0
`define RPVA_SETTLE_NS   20
`define RPVA_CLK_NS      10
`define RPVA_SETTLE_CYC  ((`RPVA_SETTLE_NS + `RPVA_CLK_NS - 1) / `RPVA_CLK_NS)
`define RPVA_CODE_ZERO   4'h0
`define RPVA_CODE_ONE    4'h1
`define RPVA_CODE_LOW    4'h2
`define RPVA_CODE_HIGH   4'h3
`define RPVA_CODE_IGNORE 4'h4
`define RPVA_CODE_PRE    4'h5
`define RPVA_CODE_OTHER  4'h6
`endif

// [rpva_pkg.sv]
`default_nettype none
package rpva_pkg;
  // one symbol per pin position of a vector
  typedef logic [3:0] rpva_code_type;
  // per-pin tester drive: level, enable
  typedef struct packed {
    logic lvl;
    logic oe;
  } rpva_drv_type;
  // check result of one vector
  typedef struct packed {
    logic done;
    logic err;
    logic rejected;
  } rpva_res_type;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_LOAD   = 3'b001,
    ST_SETTLE = 3'b010,
    ST_CHECK  = 3'b011,
    ST_DONE   = 3'b100
  } rpva_state_type;
endpackage : rpva_pkg
`default_nettype wire

// [rpva_dut_model.sv]
`default_nettype none
// behavioural registered part: preload image lands on preload pins only
module rpva_dut_model (
  input  wire  logic        ref_clk,
  input  wire  logic        reset,
  input  wire  logic        load_stb,     // apply preload image
  input  wire  logic [19:0] reg_load,     // register true-output image
  input  wire  logic [19:0] preload_mask, // pins tied to registers
  input  wire  logic [19:0] inv_mask,     // register-to-pin inversion
  input  wire  logic [19:0] pin_out,      // tester drive level
  input  wire  logic [19:0] pin_oe,       // tester drive enable
  input  wire  logic        flip,         // faulty part: outputs disagree
  output var   logic [19:0] pin_in        // level seen at the pins
);
  logic [19:0] q_q; // register true outputs
  // unused pins keep their register; only level pins loaded by this vector are compared, so stale state is never checked
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q_q <= 20'h00000;
    end else if (load_stb) begin
      q_q <= (q_q & ~preload_mask) | (reg_load & preload_mask);
    end
  end
  // driven pins follow the tester, released ones show the register
  always_comb begin
    pin_in = (pin_oe & pin_out) | (~pin_oe & (q_q ^ inv_mask ^ {20{flip}}));
  end
endmodule : rpva_dut_model
`default_nettype wire

// [register_preload_vector_applier_tb.sv]
`include "rpva_cfg.svh"
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module register_preload_vector_applier_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           ref_clk = 1'b0;
  logic                           reset = 1'b1;
  logic                           vec_valid = 1'b0;
  rpva_pkg::rpva_code_type [19:0] vec_code = {20{`RPVA_CODE_IGNORE}};
  logic [19:0]                    preload_mask = 20'h00000;
  logic [19:0]                    inv_mask = 20'h00000;
  logic                           fuse_inv = 1'b0;
  logic                           flip = 1'b0;  // part answers wrongly
  logic [19:0]                    pin_in, pin_out, pin_oe, reg_load;
  logic                           busy, load_stb, vec_done, vec_err, vec_reject, normal_stb;
  logic [3:0]                     seen;         // normal, reject, error, load
  logic                           got_done;
  int                             miscompares = 0;
  int                             cmp_count = 0;
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  rpva_applier rpva_applier_i (.ref_clk(ref_clk), .reset(reset), .vec_valid(vec_valid),
    .vec_code(vec_code), .preload_mask(preload_mask), .inv_mask(inv_mask),
    .fuse_inv(fuse_inv), .pin_in(pin_in), .busy(busy), .pin_out(pin_out), .pin_oe(pin_oe),
    .reg_load(reg_load), .load_stb(load_stb), .vec_done(vec_done), .vec_err(vec_err),
    .vec_reject(vec_reject), .normal_stb(normal_stb));
  rpva_dut_model rpva_dut_model_i (.ref_clk(ref_clk), .reset(reset), .load_stb(load_stb),
    .reg_load(reg_load), .preload_mask(preload_mask), .inv_mask(inv_mask),
    .pin_out(pin_out), .pin_oe(pin_oe), .flip(flip), .pin_in(pin_in));
  // verdict and end of run
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  // one vector in, every pulse gathered until it finishes; bounded wait
  task automatic run_vec;
    int n;
    seen = 4'h0;
    got_done = 1'b0;
    @(negedge ref_clk) vec_valid = 1'b1;
    @(negedge ref_clk) vec_valid = 1'b0;
    for (n = 0; n < 20 && !got_done; n++) begin
      seen = seen | {normal_stb, vec_reject, vec_err & vec_done, load_stb};
      got_done = (vec_done === 1'b1) || (normal_stb === 1'b1);
      if (!got_done) @(negedge ref_clk);
    end
    if (!got_done) begin
      miscompares++;
      close_out();
    end
    // let busy drop before the next vector
    repeat (2) @(negedge ref_clk);
    `CHK(busy, 1'b0)
  endtask : run_vec
  // preload vector with every other pin ignored
  task automatic prep(input logic [19:0] m, input logic [19:0] iv, input logic fz);
    vec_code = {20{`RPVA_CODE_IGNORE}};
    vec_code[0] = `RPVA_CODE_PRE;
    preload_mask = m;
    inv_mask = iv;
    fuse_inv = fz;
  endtask : prep
  // zero/one codes, stray preload code, unused pin; a faulty part must not matter
  task automatic t_reg;
    prep(20'h0000E, 20'h00000, 1'b0);
    vec_code[1] = `RPVA_CODE_ZERO;
    vec_code[2] = `RPVA_CODE_ONE;
    vec_code[3] = `RPVA_CODE_PRE;
    vec_code[5] = `RPVA_CODE_ONE;
    flip = 1'b1;
    run_vec();
    flip = 1'b0;
    `CHK(reg_load[3:1], 3'h1)
    `CHK(reg_load[5], 1'b0)
    `CHK(pin_out[2:1], 2'h2)
    `CHK(pin_oe[3:1], 3'h3)
    `CHK(seen, 4'h1)
    $display("test t_reg done");
  endtask : t_reg
  // level codes through inversion; flp makes the pin check fail
  task automatic t_lvl(input logic flp);
    prep(20'h0000E, 20'h0000C, 1'b0);
    vec_code[1] = `RPVA_CODE_HIGH;
    vec_code[2] = `RPVA_CODE_LOW;
    vec_code[3] = `RPVA_CODE_HIGH;
    flip = flp;
    run_vec();
    flip = 1'b0;
    `CHK(reg_load[3:1], 3'h3)
    `CHK(pin_oe[3:1], 3'h0)
    `CHK(seen, {2'h0, flp, 1'b1})
    $display("test t_lvl done");
  endtask : t_lvl
  // fuse-set inversion refuses level codes and leaves registers alone
  task automatic t_fuse;
    prep(20'h0000E, 20'h0000C, 1'b1);
    vec_code[1] = `RPVA_CODE_LOW;
    run_vec();
    fuse_inv = 1'b0;
    `CHK(seen, 4'h6)
    `CHK(reg_load[3:1], 3'h3)
    $display("test t_fuse done");
  endtask : t_fuse
  // no preload code at the clock pin: ordinary vector, no load
  task automatic t_norm;
    prep(20'h0000E, 20'h00000, 1'b0);
    vec_code[0] = `RPVA_CODE_LOW;
    vec_code[1] = `RPVA_CODE_ONE;
    run_vec();
    `CHK(seen, 4'h8)
    `CHK(reg_load[3:1], 3'h3)
    $display("test t_norm done");
  endtask : t_norm
  // reset for three cycles, then the scenarios
  initial begin
    repeat (3) @(negedge ref_clk);
    reset = 1'b0;
    t_reg();
    t_lvl(1'b0);
    t_lvl(1'b1);
    t_fuse();
    t_norm();
    close_out();
  end
endmodule : register_preload_vector_applier_tb
`default_nettype wire
